// file: cpd_pkg.sv
// Purpose: Shared constants and types of the decoder and sequencer.
// Assumes: 8-bit data, 16-bit address, one clock.
// Notes:   Per-opcode cycle and byte figures live in the decoder case table; entry and extra cycles live here.
package cpd_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Vector locations and stack page.
   localparam logic [15:0] VEC_NMI   = 16'hFFFA;
   localparam logic [15:0] VEC_RESET = 16'hFFFC;
   localparam logic [15:0] VEC_IRQ   = 16'hFFFE;
   localparam logic [7:0]  STACK_PAGE = 8'h01;
   localparam logic [7:0]  ZERO_PAGE  = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values.
   localparam logic [7:0]  RESET_A  = 8'h00;
   localparam logic [7:0]  RESET_X  = 8'h00;
   localparam logic [7:0]  RESET_SP = 8'hFF;
   localparam logic [7:0]  RESET_P  = 8'h34;
   localparam logic [15:0] RESET_PC = 16'h0000;

   ////////////////////////////////////////////////////////////////////////////
   // Status register bit positions.
   localparam int P_N = 7;
   localparam int P_V = 6;
   localparam int P_U = 5;
   localparam int P_B = 4;
   localparam int P_D = 3;
   localparam int P_I = 2;
   localparam int P_Z = 1;
   localparam int P_C = 0;

   ////////////////////////////////////////////////////////////////////////////
   // Timing steps within an instruction; step 0 is the opcode fetch.
   localparam logic [2:0] STEP_1        = 3'h1;
   localparam logic [2:0] STEP_2        = 3'h2;
   localparam logic [2:0] STEP_3        = 3'h3;
   localparam logic [2:0] STEP_4        = 3'h4;
   localparam logic [2:0] STEP_VEC_LO   = 3'h5;
   localparam logic [2:0] STEP_VEC_HI   = 3'h6;
   localparam logic [2:0] ENTRY_CYCLES  = 3'h7;
   localparam logic [2:0] EXTRA_PAGE    = 3'h1;
   localparam logic [2:0] EXTRA_BRANCH  = 3'h1;
   localparam logic [2:0] RMW_READ_BACK = 3'h3;

   ////////////////////////////////////////////////////////////////////////////
   // Enumerations.
   typedef enum logic [4:0] {
      OP_NOP, OP_ADC, OP_SBC, OP_TSB, OP_TRB, OP_JSR, OP_PHP, OP_PLP, OP_TXS,
      OP_TSX, OP_BIT, OP_CPX, OP_BNE, OP_DEX, OP_STZ, OP_LDA, OP_BRK
   } cpd_op_t;

   typedef enum logic [3:0] {
      AM_IMP, AM_IMM, AM_ZP, AM_ZPX, AM_ABS, AM_ABSX, AM_ZPI, AM_REL, AM_STK
   } cpd_mode_t;

   typedef enum logic [1:0] {
      INT_NONE, INT_IRQ, INT_NMI, INT_RESET
   } cpd_kind_t;

   typedef enum logic {
      ST_FETCH = 1'b0,
      ST_EXEC  = 1'b1
   } cpd_state_t;

   typedef struct packed {
      cpd_op_t   op;
      cpd_mode_t mode;
      logic [2:0] cycles;
      logic [1:0] bytes;
   } cpd_decode_t;

endpackage

// file: cpd_decode.sv
// Purpose: Maps an opcode byte to operation, addressing mode, base cycles and length.
// Assumes: Pure combinational; the caller samples it on the fetch cycle.
// Notes:   Every byte not listed decodes as a one-byte, two-cycle no-operation.
`timescale 1ns/10ps
module cpd_decode
   import cpd_pkg::*;
(
   input  wire logic [7:0] opcode_in,
   output cpd_op_t         op_out,
   output cpd_mode_t       mode_out,
   output logic [2:0]      cycles_out,
   output logic [1:0]      bytes_out
);

   function automatic cpd_decode_t decode(input logic [7:0] opc);
      case (opc)
         8'h00: decode = '{OP_BRK, AM_STK,  3'h7, 2'h2};
         8'h69: decode = '{OP_ADC, AM_IMM,  3'h2, 2'h2};
         8'h65: decode = '{OP_ADC, AM_ZP,   3'h3, 2'h2};
         8'h75: decode = '{OP_ADC, AM_ZPX,  3'h4, 2'h2};
         8'h6D: decode = '{OP_ADC, AM_ABS,  3'h4, 2'h3};
         8'h7D: decode = '{OP_ADC, AM_ABSX, 3'h4, 2'h3};
         8'h72: decode = '{OP_ADC, AM_ZPI,  3'h5, 2'h2};
         8'hE9: decode = '{OP_SBC, AM_IMM,  3'h2, 2'h2};
         8'hE5: decode = '{OP_SBC, AM_ZP,   3'h3, 2'h2};
         8'hF5: decode = '{OP_SBC, AM_ZPX,  3'h4, 2'h2};
         8'hED: decode = '{OP_SBC, AM_ABS,  3'h4, 2'h3};
         8'hFD: decode = '{OP_SBC, AM_ABSX, 3'h4, 2'h3};
         8'hF2: decode = '{OP_SBC, AM_ZPI,  3'h5, 2'h2};
         8'h04: decode = '{OP_TSB, AM_ZP,   3'h5, 2'h2};
         8'h0C: decode = '{OP_TSB, AM_ABS,  3'h6, 2'h3};
         8'h14: decode = '{OP_TRB, AM_ZP,   3'h5, 2'h2};
         8'h1C: decode = '{OP_TRB, AM_ABS,  3'h6, 2'h3};
         8'h20: decode = '{OP_JSR, AM_ABS,  3'h6, 2'h3};
         8'h08: decode = '{OP_PHP, AM_STK,  3'h3, 2'h1};
         8'h28: decode = '{OP_PLP, AM_STK,  3'h4, 2'h1};
         8'h9A: decode = '{OP_TXS, AM_IMP,  3'h2, 2'h1};
         8'hBA: decode = '{OP_TSX, AM_IMP,  3'h2, 2'h1};
         8'h89: decode = '{OP_BIT, AM_IMM,  3'h2, 2'h2};
         8'h24: decode = '{OP_BIT, AM_ZP,   3'h3, 2'h2};
         8'h34: decode = '{OP_BIT, AM_ZPX,  3'h4, 2'h2};
         8'h2C: decode = '{OP_BIT, AM_ABS,  3'h4, 2'h3};
         8'h3C: decode = '{OP_BIT, AM_ABSX, 3'h4, 2'h3};
         8'hE0: decode = '{OP_CPX, AM_IMM,  3'h2, 2'h2};
         8'hE4: decode = '{OP_CPX, AM_ZP,   3'h3, 2'h2};
         8'hEC: decode = '{OP_CPX, AM_ABS,  3'h4, 2'h3};
         8'hD0: decode = '{OP_BNE, AM_REL,  3'h2, 2'h2};
         8'hCA: decode = '{OP_DEX, AM_IMP,  3'h2, 2'h1};
         8'h64: decode = '{OP_STZ, AM_ZP,   3'h3, 2'h2};
         8'h74: decode = '{OP_STZ, AM_ZPX,  3'h4, 2'h2};
         8'h9C: decode = '{OP_STZ, AM_ABS,  3'h4, 2'h3};
         8'h9E: decode = '{OP_STZ, AM_ABSX, 3'h5, 2'h3};
         8'hA9: decode = '{OP_LDA, AM_IMM,  3'h2, 2'h2};
         8'hA5: decode = '{OP_LDA, AM_ZP,   3'h3, 2'h2};
         8'hB5: decode = '{OP_LDA, AM_ZPX,  3'h4, 2'h2};
         8'hAD: decode = '{OP_LDA, AM_ABS,  3'h4, 2'h3};
         8'hBD: decode = '{OP_LDA, AM_ABSX, 3'h4, 2'h3};
         8'hB2: decode = '{OP_LDA, AM_ZPI,  3'h5, 2'h2};
         default: decode = '{OP_NOP, AM_IMP, 3'h2, 2'h1};
      endcase
   endfunction

   wire cpd_decode_t dec_w = decode(opcode_in);

   assign op_out     = dec_w.op;
   assign mode_out   = dec_w.mode;
   assign cycles_out = dec_w.cycles;
   assign bytes_out  = dec_w.bytes;

endmodule

// file: cpd_core.sv
// Purpose: Instruction sequencer with vector fetch, interrupt entry and a small execute unit.
// Assumes: Combinational-read memory; data_in is sampled at the end of each bus cycle.
// Notes:   One bus cycle per clock; binary arithmetic only, decimal mode is not applied.
//
// Overview of operation
// RULE_01: Vectors come from FFFE, FFFC and FFFA.
// RULE_02: Vector pull indicator low only during vector reads.
// RULE_03: Interrupt entry clears decimal, sets interrupt mask.
// RULE_04: Add adds operand and carry into accumulator.
// RULE_05: Subtract takes operand and borrow from accumulator.
// RULE_06: Test-set writes memory OR accumulator back.
// RULE_07: Test-clear writes memory AND NOT accumulator back.
// RULE_08: Call pushes return address, jumps to target.
// RULE_09: Push flags writes status, decrements stack pointer.
// RULE_10: Pull flags increments stack pointer, loads status.
// RULE_11: X copied into stack pointer.
// RULE_12: Stack pointer copied into X.
// RULE_13: Bit test compares memory with accumulator, no store.
// RULE_14: Compare X sets flags from X minus operand.
// RULE_15: Branch adds signed offset when zero clear.
// RULE_16: Decrement X subtracts one from X.
// RULE_17: Store zero writes zero to effective address.
// RULE_18: Load accumulator from operand in several modes.
// RULE_19: Extra cycle for page cross and taken branch.
// RULE_20: Unassigned opcodes act as no-operation.
`timescale 1ns/10ps
module cpd_core
   import cpd_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        reset_in,
   input  wire logic [7:0]  data_in,
   input  wire logic        maskable_interrupt_request_n_in,
   input  wire logic        nonmaskable_interrupt_n_in,
   output logic [15:0]      addr_out,
   output logic [7:0]       data_out,
   output logic             write_out,
   output logic             vector_pull_indicator_n_out,
   output logic             opcode_fetch_out,
   output logic [7:0]       acc_out,
   output logic [7:0]       x_out,
   output logic [7:0]       sp_out,
   output logic [7:0]       status_out,
   output logic [2:0]       cycles_out,
   output logic [1:0]       bytes_out
);

   cpd_state_t  state_q;
   cpd_op_t     op_q;
   cpd_mode_t   mode_q;
   cpd_kind_t   kind_q;
   logic [2:0]  t_q;
   logic [2:0]  tot_q;
   logic [1:0]  len_q;
   logic [15:0] pc_q;
   logic [7:0]  sp_q;
   logic [7:0]  a_q;
   logic [7:0]  x_q;
   logic [7:0]  p_q;
   logic [7:0]  lo_q;
   logic [7:0]  hi_q;
   logic [7:0]  tmp_q;
   logic [1:0]  pin_s1_q;
   logic [1:0]  pin_s2_q;
   logic [1:0]  pin_s3_q;
   logic [1:0]  pin_q;
   logic        nmi_pend_q;

   cpd_op_t     dec_op;
   cpd_mode_t   dec_mode;
   logic [2:0]  dec_cycles;
   logic [1:0]  dec_bytes;

   cpd_decode u_decode (
      .opcode_in  (data_in),
      .op_out     (dec_op),
      .mode_out   (dec_mode),
      .cycles_out (dec_cycles),
      .bytes_out  (dec_bytes)
   );

   function automatic logic reads_operand(input cpd_op_t op);
      reads_operand = (op == OP_ADC) || (op == OP_SBC) || (op == OP_BIT) ||
                      (op == OP_LDA) || (op == OP_CPX);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt pins: four flops; stages two and three must agree.
   wire nmi_fall   = pin_q[1] && !pin_s2_q[1] && !pin_s3_q[1];
   wire irq_active = !pin_q[0] && !p_q[P_I];
   wire take_int   = nmi_pend_q || irq_active;
   wire fetching   = (state_q == ST_FETCH);
   wire in_exec    = (state_q == ST_EXEC);

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         pin_s1_q <= 2'h3;
         pin_s2_q <= 2'h3;
         pin_s3_q <= 2'h3;
         pin_q    <= 2'h3;
      end else begin
         pin_s1_q <= {nonmaskable_interrupt_n_in, maskable_interrupt_request_n_in};
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
         for (int i = 0; i < 2; i++) begin
            if (pin_s2_q[i] == pin_s3_q[i]) begin
               pin_q[i] <= pin_s3_q[i];
            end
         end
      end
   end

   // A falling edge seen in the cycle the pending flag is consumed is kept.
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         nmi_pend_q <= 1'b0;
      end else if (nmi_fall) begin
         nmi_pend_q <= 1'b1;
      end else if (fetching && nmi_pend_q) begin
         nmi_pend_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Step control and effective address.
   wire        is_rmw     = (op_q == OP_TSB) || (op_q == OP_TRB);
   wire        is_data    = (mode_q == AM_ZP) || (mode_q == AM_ZPX) || (mode_q == AM_ABS) ||
                            (mode_q == AM_ABSX) || (mode_q == AM_ZPI);
   wire [8:0]  lo_plus_x  = {1'b0, data_in} + {1'b0, x_q};
   wire        page_cross = (t_q == STEP_1) && (mode_q == AM_ABSX) && reads_operand(op_q) &&
                            lo_plus_x[8];
   wire        br_taken   = (t_q == STEP_1) && (op_q == OP_BNE) && !p_q[P_Z];
   wire        extend     = page_cross || br_taken;
   wire        last       = in_exec && (t_q == tot_q - STEP_1) && !extend;
   wire        rmw_read   = is_rmw && (t_q == tot_q - RMW_READ_BACK);
   wire        mem_step   = in_exec && is_data && op_q != OP_JSR && (last || rmw_read);
   wire        hw_entry   = (op_q == OP_BRK) && (kind_q != INT_NONE);
   wire [7:0]  zp_idx     = lo_q + x_q;
   wire [7:0]  zp_next    = lo_q + 8'h01;
   wire [15:0] abs_idx    = {hi_q, lo_q} + {8'h00, x_q};
   wire [15:0] stack_addr = {STACK_PAGE, sp_q};
   wire [15:0] vec_base   = (kind_q == INT_NMI)   ? VEC_NMI :
                            (kind_q == INT_RESET) ? VEC_RESET : VEC_IRQ;   // see RULE_01
   wire [15:0] br_target  = pc_q + {{8{lo_q[7]}}, lo_q};                    // see RULE_15
   wire [7:0]  push_p     = p_q | (8'h01 << P_U) | ((kind_q == INT_NONE) ? (8'h01 << P_B) : 8'h00);

   logic [15:0] ea;
   always_comb begin
      case (mode_q)
         AM_ZP:   ea = {ZERO_PAGE, lo_q};
         AM_ZPX:  ea = {ZERO_PAGE, zp_idx};
         AM_ABS:  ea = {hi_q, lo_q};
         AM_ABSX: ea = abs_idx;
         AM_ZPI:  ea = {hi_q, tmp_q};
         default: ea = pc_q;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Arithmetic.
   wire [7:0] alu_b   = (op_q == OP_SBC) ? ~data_in : data_in;                // see RULE_05
   wire [8:0] sum9    = {1'b0, a_q} + {1'b0, alu_b} + {8'h00, p_q[P_C]};      // see RULE_04
   wire       ovf     = (a_q[7] == alu_b[7]) && (sum9[7] != a_q[7]);
   wire [8:0] cmp9    = {1'b0, x_q} + {1'b0, ~data_in} + 9'h001;              // see RULE_14
   wire [7:0] rmw_val = (op_q == OP_TSB) ? (tmp_q | a_q) : (tmp_q & ~a_q);    // see RULE_06 RULE_07
   wire [7:0] x_dec   = x_q - 8'h01;                                          // see RULE_16

   ////////////////////////////////////////////////////////////////////////////
   // Bus drive.
   always_comb begin
      addr_out = pc_q;
      data_out = 8'h00;
      write_out = 1'b0;
      vector_pull_indicator_n_out = 1'b1;
      if (in_exec) begin
         case (op_q)
            OP_BRK: begin
               if (t_q == STEP_2 || t_q == STEP_3 || t_q == STEP_4) begin
                  addr_out  = stack_addr;
                  write_out = (kind_q != INT_RESET);
                  data_out  = (t_q == STEP_2) ? pc_q[15:8] : (t_q == STEP_3) ? pc_q[7:0] : push_p;
               end else if (t_q == STEP_VEC_LO || t_q == STEP_VEC_HI) begin
                  addr_out = (t_q == STEP_VEC_LO) ? vec_base : vec_base + 16'h0001;   // see RULE_01
                  vector_pull_indicator_n_out = 1'b0;                                 // see RULE_02
               end
            end
            OP_JSR: begin
               if (t_q == STEP_3 || t_q == STEP_4) begin                             // see RULE_08
                  addr_out  = stack_addr;
                  write_out = 1'b1;
                  data_out  = (t_q == STEP_3) ? pc_q[15:8] : pc_q[7:0];
               end
            end
            OP_PHP: begin
               if (t_q == STEP_2) begin                                              // see RULE_09
                  addr_out  = stack_addr;
                  write_out = 1'b1;
                  data_out  = push_p;
               end
            end
            OP_PLP: begin
               if (t_q >= STEP_2) begin
                  addr_out = stack_addr;
               end
            end
            default: begin
               if (mode_q == AM_ZPI && t_q == STEP_2) begin
                  addr_out = {ZERO_PAGE, lo_q};
               end else if (mode_q == AM_ZPI && t_q == STEP_3) begin
                  addr_out = {ZERO_PAGE, zp_next};
               end else if (mem_step) begin
                  addr_out  = ea;
                  write_out = (op_q == OP_STZ) || (is_rmw && last);
                  data_out  = (op_q == OP_STZ) ? 8'h00 : rmw_val;                    // see RULE_17
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer.
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         state_q <= ST_EXEC;
         t_q     <= STEP_1;
         tot_q   <= ENTRY_CYCLES;
         op_q    <= OP_BRK;
         mode_q  <= AM_STK;
         len_q   <= 2'h1;
         kind_q  <= INT_RESET;
      end else if (fetching) begin
         state_q <= ST_EXEC;
         t_q     <= STEP_1;
         op_q    <= take_int ? OP_BRK : dec_op;                                     // see RULE_20
         mode_q  <= take_int ? AM_STK : dec_mode;
         tot_q   <= take_int ? ENTRY_CYCLES : dec_cycles;
         len_q   <= take_int ? 2'h1 : dec_bytes;
         kind_q  <= !take_int ? INT_NONE : nmi_pend_q ? INT_NMI : INT_IRQ;
      end else begin
         state_q <= last ? ST_FETCH : ST_EXEC;
         t_q     <= last ? 3'h0 : t_q + STEP_1;
         tot_q   <= tot_q + (page_cross ? EXTRA_PAGE : 3'h0) + (br_taken ? EXTRA_BRANCH : 3'h0);  // see RULE_19
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Program counter, operand latches and stack pointer.
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         pc_q  <= RESET_PC;
         sp_q  <= RESET_SP;
         lo_q  <= 8'h00;
         hi_q  <= 8'h00;
         tmp_q <= 8'h00;
      end else if (fetching) begin
         pc_q <= take_int ? pc_q : pc_q + 16'h0001;
      end else begin
         if (t_q == STEP_1) begin
            lo_q <= data_in;
            if (len_q != 2'h1 && !hw_entry) begin
               pc_q <= pc_q + 16'h0001;
            end
         end
         if (t_q == STEP_2 && len_q == 2'h3) begin
            hi_q <= data_in;
            if (op_q != OP_JSR) begin
               pc_q <= pc_q + 16'h0001;
            end
         end
         if (mode_q == AM_ZPI && t_q == STEP_2) begin
            tmp_q <= data_in;
         end
         if (mode_q == AM_ZPI && t_q == STEP_3) begin
            hi_q <= data_in;
         end
         if (rmw_read) begin
            tmp_q <= data_in;
         end
         if (op_q == OP_BNE && t_q == STEP_2) begin
            pc_q <= br_target;                                                      // see RULE_15
         end
         if (op_q == OP_JSR && t_q == STEP_VEC_LO) begin
            pc_q <= {data_in, lo_q};                                                // see RULE_08
         end
         if (op_q == OP_BRK && t_q == STEP_VEC_LO) begin
            lo_q <= data_in;
         end
         if (op_q == OP_BRK && t_q == STEP_VEC_HI) begin
            pc_q <= {data_in, lo_q};                                                // see RULE_01
         end
         if ((op_q == OP_BRK && t_q >= STEP_2 && t_q <= STEP_4) ||
             (op_q == OP_JSR && (t_q == STEP_3 || t_q == STEP_4)) ||
             (op_q == OP_PHP && t_q == STEP_2)) begin
            sp_q <= sp_q - 8'h01;                                                   // see RULE_09
         end
         if (op_q == OP_PLP && t_q == STEP_2) begin
            sp_q <= sp_q + 8'h01;                                                   // see RULE_10
         end
         if (op_q == OP_TXS && last) begin
            sp_q <= x_q;                                                            // see RULE_11
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Accumulator, X and status.
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         a_q <= RESET_A;
         x_q <= RESET_X;
         p_q <= RESET_P;
      end else if (in_exec) begin
         if (op_q == OP_BRK && t_q == STEP_4) begin
            p_q[P_D] <= 1'b0;                                                       // see RULE_03
            p_q[P_I] <= 1'b1;
         end
         if (op_q == OP_PLP && t_q == STEP_3) begin
            p_q <= data_in | (8'h01 << P_U) | (8'h01 << P_B);                       // see RULE_10
         end
         if (rmw_read) begin
            p_q[P_Z] <= (data_in & a_q) == 8'h00;                                   // see RULE_06 RULE_07
         end
         if (last) begin
            case (op_q)
               OP_ADC, OP_SBC: begin                                                // see RULE_04 RULE_05
                  a_q      <= sum9[7:0];
                  p_q[P_C] <= sum9[8];
                  p_q[P_V] <= ovf;
                  p_q[P_N] <= sum9[7];
                  p_q[P_Z] <= sum9[7:0] == 8'h00;
               end
               OP_LDA: begin                                                        // see RULE_18
                  a_q      <= data_in;
                  p_q[P_N] <= data_in[7];
                  p_q[P_Z] <= data_in == 8'h00;
               end
               OP_BIT: begin                                                        // see RULE_13
                  p_q[P_Z] <= (data_in & a_q) == 8'h00;
                  if (mode_q != AM_IMM) begin
                     p_q[P_N] <= data_in[7];
                     p_q[P_V] <= data_in[6];
                  end
               end
               OP_CPX: begin                                                        // see RULE_14
                  p_q[P_C] <= cmp9[8];
                  p_q[P_N] <= cmp9[7];
                  p_q[P_Z] <= cmp9[7:0] == 8'h00;
               end
               OP_TSX: begin                                                        // see RULE_12
                  x_q      <= sp_q;
                  p_q[P_N] <= sp_q[7];
                  p_q[P_Z] <= sp_q == 8'h00;
               end
               OP_DEX: begin                                                        // see RULE_16
                  x_q      <= x_dec;
                  p_q[P_N] <= x_dec[7];
                  p_q[P_Z] <= x_dec == 8'h00;
               end
               default: begin
               end
            endcase
         end
      end
   end

   assign opcode_fetch_out = fetching;
   assign acc_out          = a_q;
   assign x_out            = x_q;
   assign sp_out           = sp_q;
   assign status_out       = p_q;
   assign cycles_out       = tot_q;
   assign bytes_out        = len_q;

endmodule

// file: cpd_mem_model.sv
// Purpose: Zero-wait memory on the processor bus.
// Assumes: Reads answer at once; writes land at the rising edge.
// Notes:   Unwritten bytes read as EA, a harmless no-operation.
`timescale 1ns/10ps
module cpd_mem_model (
   input  wire logic        clk_in,
   input  wire logic [15:0] addr_in,
   input  wire logic [7:0]  data_in,
   input  wire logic        write_in,
   output logic [7:0]       data_out
);
   logic [7:0] mem [0:65535];
   initial begin
      for (int i = 0; i < 65536; i++) begin
         mem[i] = 8'hEA;
      end
   end
   assign data_out = mem[addr_in];
   always @(posedge clk_in) begin
      if (write_in) begin
         mem[addr_in] <= data_in;
      end
   end
endmodule

// file: cpd_core_monitor.sv
// Purpose: Bus and vector checks on the sequencer ports.
// Assumes: One clock; synchronous active-high reset.
// Notes:   Stack checks cover writes to page 01 only.
`timescale 1ns/10ps
module cpd_core_monitor
   import cpd_pkg::*;
(
   input wire logic        clk_in,
   input wire logic        reset_in,
   input wire logic [15:0] addr_out,
   input wire logic        write_out,
   input wire logic        vector_pull_indicator_n_out,
   input wire logic        opcode_fetch_out,
   input wire logic [7:0]  sp_out,
   input wire logic [7:0]  status_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (reset_in);
   wire vp = !vector_pull_indicator_n_out;
   wire stk_wr = write_out && (addr_out[15:8] == STACK_PAGE);
   vec_pull_addr_a: assert property (vp |-> addr_out >= 16'hFFFA)
      else $error("vector address low");
   vec_pull_pair_a: assert property ($rose(vp) |-> !addr_out[0] ##1 (vp && addr_out[0]) ##1 !vp)
      else $error("vector pull not two cycles");
   entry_flags_a: assert property (vp && addr_out[0] |=> status_out[P_I] && !status_out[P_D])
      else $error("entry flags wrong");
   vec_no_write_a: assert property (vp |-> !write_out)
      else $error("write during vector pull");
   fetch_read_a: assert property (opcode_fetch_out |-> !write_out && !vp)
      else $error("fetch not a plain read");
   min_length_a: assert property (opcode_fetch_out |=> !opcode_fetch_out)
      else $error("one-cycle instruction");
   stack_addr_a: assert property (stk_wr |-> addr_out[7:0] == sp_out)
      else $error("push address wrong");
   stack_dec_a: assert property (stk_wr |=> sp_out == $past(sp_out) - 8'h01)
      else $error("push left stack pointer");
endmodule

// file: cpd_core_tb.sv
// Purpose: One program run through the sequencer, checked.
// Assumes: Zero-wait memory model; interrupt pins idle high.
// Notes:   Fetches are logged at the falling edge, where outputs have settled.
`timescale 1ns/10ps
module cpd_core_tb;
   import cpd_pkg::*;
   logic        clk_in, reset_in, write_out, vpn, fetch;
   logic [15:0] addr_out;
   logic [7:0]  rd_data, data_out, acc, x, sp, status;
   int          mismatches, compares, cyc, nf, vcnt;
   logic [15:0] fpc [32];
   int          fcyc [32];
   logic [15:0] exp_pc [19] = '{16'h0200, 16'h0201, 16'h0202, 16'h0204, 16'h0206, 16'h0208, 16'h0209,
      16'h020A, 16'h020B, 16'h020D, 16'h020F, 16'h0211, 16'h0213, 16'h0215, 16'h0300, 16'h0400,
      16'h0401, 16'h0404, 16'h0406};
   int          exp_cyc [18] = '{4, 3, 2, 2, 2, 2, 2, 2, 5, 5, 3, 2, 2, 6, 7, 2, 5, 3};
   logic [7:0]  prog [24] = '{8'h28, 8'h08, 8'hA9, 8'h05, 8'h69, 8'h03, 8'hE9, 8'h01, 8'hBA, 8'hCA,
      8'h9A, 8'h04, 8'h10, 8'h14, 8'h11, 8'h64, 8'h12, 8'hE0, 8'hFB, 8'hD0, 8'h05, 8'h20, 8'h00, 8'h03};
   cpd_mem_model cpd_mem_model_inst (.clk_in(clk_in), .addr_in(addr_out), .data_in(data_out),
      .write_in(write_out), .data_out(rd_data));
   cpd_core cpd_core_inst (.clk_in(clk_in), .reset_in(reset_in), .data_in(rd_data),
      .maskable_interrupt_request_n_in(1'b1), .nonmaskable_interrupt_n_in(1'b1), .addr_out(addr_out),
      .data_out(data_out), .write_out(write_out), .vector_pull_indicator_n_out(vpn),
      .opcode_fetch_out(fetch), .acc_out(acc), .x_out(x), .sp_out(sp), .status_out(status),
      .cycles_out(), .bytes_out());
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_in = 1'b0;
      forever #25 clk_in = ~clk_in;
   end
   always @(negedge clk_in) begin
      if (reset_in) begin
         cyc = 0;
         nf = 0;
         vcnt = 0;
      end else begin
         if (fetch === 1'b1 && nf < 32) begin
            fpc[nf] = addr_out;
            fcyc[nf] = cyc;
            nf++;
         end
         vcnt += (vpn === 1'b0);
         cyc++;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task report_and_stop();
      $display("Comparisons %0d, mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task st(input logic [15:0] a, input logic [15:0] v);
      {cpd_mem_model_inst.mem[a], cpd_mem_model_inst.mem[a + 16'h0001]} = v;
   endtask
   function logic [7:0] m(input logic [15:0] a);
      return cpd_mem_model_inst.mem[a];
   endfunction
   // Reset runs at 0200, break at 0400.
   task load_program();
      for (int i = 0; i < 24; i++) begin
         cpd_mem_model_inst.mem[16'h0200 + i] = prog[i];
      end
      st(16'hFFFC, 16'h0002);
      st(16'hFFFE, 16'h0004);
      st(16'h0300, 16'h0000);
      st(16'h0400, 16'h02BD);
      st(16'h0402, 16'h1005);
      st(16'h0404, 16'hD000);
      st(16'h01FD, 16'h08EA);
      st(16'h0010, 16'h01FF);
      st(16'h0012, 16'hAAEA);
      st(16'h060B, 16'h5AEA);
   endtask
   task run_program();
      for (int n = 0; n < 400 && nf < 19; n++) begin
         @(negedge clk_in);
      end
      cmp(16'(nf >= 19), 16'h0001);
   endtask
   task check_fetch_trace();
      for (int i = 0; i < 18; i++) begin
         cmp(fpc[i], exp_pc[i]);
         cmp(16'(fcyc[i + 1] - fcyc[i]), 16'(exp_cyc[i]));
      end
      cmp(vcnt[15:0], 16'h0004);
   endtask
   task check_registers();
      cmp({acc, x}, 16'h5AFB);
      cmp({sp, 6'h00, status[P_D], status[P_I]}, 16'hF601);
   endtask
   task check_memory();
      cmp({8'h00, m(16'h01FD)}, 16'h0038);
      cmp({m(16'h0010), m(16'h0011)}, 16'h07F9);
      cmp({8'h00, m(16'h0012)}, 16'h0000);
      cmp({m(16'h01FB), m(16'h01FA)}, 16'h0217);
      cmp({m(16'h01F9), m(16'h01F8)}, 16'h0302);
      cmp({8'h00, m(16'h01F7)}, 16'h003B);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      reset_in = 1'b1;
      mismatches = 0;
      compares = 0;
      @(negedge clk_in);
      load_program();
      repeat (3) @(negedge clk_in);
      reset_in = 1'b0;
      run_program();
      check_fetch_trace();
      check_registers();
      check_memory();
      report_and_stop();
   end
   // About 70 cycles are needed.
   initial begin
      #200000;
      mismatches++;
      report_and_stop();
   end
endmodule
bind cpd_core cpd_core_monitor cpd_core_monitor_inst (.clk_in, .reset_in, .addr_out, .write_out,
   .vector_pull_indicator_n_out, .opcode_fetch_out, .sp_out, .status_out);
